// File: shared/bdc_pkg.sv
// constants and types for the board dram controller with bus time-out monitor
// assumes one 100 MHz clock and a synchronous active-high reset
package bdc_pkg;
  // ==========================================================================
  // timing
  localparam int TIMEOUT_CLOCKS = 1024;
  localparam int WRITE_CAS_CLOCKS = 1;
  localparam int STRETCH_MARGIN = 2;
  localparam int CNT_W = 4;
  localparam int TO_W = 11;
  // ==========================================================================
  // controller states
  typedef enum logic [5:0] {
    BDC_IDLE  = 6'h01,
    BDC_PRE   = 6'h02,
    BDC_RAS   = 6'h04,
    BDC_CAS   = 6'h08,
    BDC_DONE  = 6'h10,
    BDC_WAITE = 6'h20
  } bdc_state_t;
endpackage

// File: rtl/bdc_timeout.sv
// bus time-out monitor: counts clocks of an unfinished bus cycle
// assumes the cycle strobe and completion level are synchronous to clock
`timescale 1ns/10ps
`default_nettype none
module bdc_timeout #(
  parameter int LIMIT = bdc_pkg::TIMEOUT_CLOCKS
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // bus cycle
  input  wire logic cycle_active,
  input  wire logic cycle_done,
  // software clear
  input  wire logic request_clear,
  // results
  output logic      force_ready,
  output logic      timeout_indicator,
  output logic      nmi_factor,
  output logic      bus_error_interrupt_line
);
  logic [bdc_pkg::TO_W-1:0] count;
  logic                     hit_limit;

  // ==========================================================================
  // counter
  assign hit_limit = (count == bdc_pkg::TO_W'(LIMIT - 1)) && cycle_active && !cycle_done;

  // restarts from zero whenever no cycle runs, so each cycle is timed afresh
  always_ff @(posedge clock) begin
    if (rst || !cycle_active || cycle_done || force_ready) begin
      count <= '0;
    end else begin
      count <= count + 1'b1;
    end
  end

  // one-cycle forced ready ends the stalled cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      force_ready <= 1'b0;
    end else begin
      force_ready <= hit_limit;
    end
  end

  // sticky flags; a new time-over in the clear cycle wins over the clear
  always_ff @(posedge clock) begin
    if (rst) begin
      timeout_indicator        <= 1'b0;
      nmi_factor               <= 1'b0;
      bus_error_interrupt_line <= 1'b0;
    end else if (hit_limit) begin
      timeout_indicator        <= 1'b1;
      nmi_factor               <= 1'b1;
      bus_error_interrupt_line <= 1'b1;
    end else if (request_clear) begin
      timeout_indicator        <= 1'b0;
      nmi_factor               <= 1'b0;
      bus_error_interrupt_line <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: rtl/bdc_dram_ctrl.sv
// dram controller between the processor bus and dram with bus time-out monitor
// assumes processor strobes synchronous to clock and dram timing set by ports
`timescale 1ns/10ps
`default_nettype none
module bdc_dram_ctrl #(
  parameter int ADDR_W  = 22,
  parameter int ROW_LSB = 11,
  parameter int LANES   = 4,
  parameter int LIMIT   = bdc_pkg::TIMEOUT_CLOCKS
) (
  // clock and reset
  input  wire logic                       clock,
  input  wire logic                       rst,
  // processor bus
  input  wire logic                       address_strobe,
  input  wire logic                       data_strobe_n,
  input  wire logic                       dram_select,
  input  wire logic                       write,
  input  wire logic [ADDR_W-1:0]          address,
  input  wire logic [LANES-1:0]           byte_enable,
  output logic                            wait_n,
  // configuration
  input  wire logic                       page_mode,
  input  wire logic [bdc_pkg::CNT_W-1:0]  precharge_clocks,
  input  wire logic [bdc_pkg::CNT_W-1:0]  ras_low_clocks,
  input  wire logic [bdc_pkg::CNT_W-1:0]  read_cas_clocks,
  // dram
  output logic                            row_strobe_n,
  output logic [LANES-1:0]                byte_column_strobe_n,
  output logic                            write_enable_n,
  output logic                            row_hit,
  // time-out monitor
  input  wire logic                       request_clear,
  output logic                            timeout_indicator,
  output logic                            nmi_factor,
  output logic                            bus_error_interrupt_line
);
  localparam int CW = bdc_pkg::CNT_W;
  localparam int RW = ADDR_W - ROW_LSB;

  bdc_pkg::bdc_state_t state;
  logic [CW-1:0]       count;
  logic [CW-1:0]       ras_count;
  logic [RW-1:0]       open_row;
  logic                row_open;
  logic                first_of_run;
  logic                cycle_active;
  logic                dram_done;
  logic                force_ready;
  logic                same_row;
  logic [CW-1:0]       cas_width;

  // ==========================================================================
  // helpers
  // at least one clock for any programmed count
  function automatic logic [CW-1:0] at_least_one(input logic [CW-1:0] v);
    return (v == '0) ? CW'(1) : v;
  endfunction

  // read column width, stretched on a first access when the row-low minimum is at least two above it
  function automatic logic [CW-1:0] read_width(input logic [CW-1:0] ras,
                                               input logic [CW-1:0] cas,
                                               input logic          first);
    logic [CW:0] need;
    need = {1'b0, cas} + (CW+1)'(bdc_pkg::STRETCH_MARGIN);
    if (first && ({1'b0, ras} >= need)) begin
      return ras - CW'(1);
    end
    return at_least_one(cas);
  endfunction

  // ==========================================================================
  // cycle decode
  assign cycle_active = address_strobe || !data_strobe_n;
  assign same_row     = row_open && (address[ADDR_W-1:ROW_LSB] == open_row);

  // width chosen when the column strobe opens
  always_comb begin
    cas_width = CW'(bdc_pkg::WRITE_CAS_CLOCKS);
    if (!write) begin
      cas_width = read_width(ras_low_clocks, read_cas_clocks, first_of_run || !page_mode);
    end else if (!page_mode && ras_low_clocks >= CW'(bdc_pkg::STRETCH_MARGIN)) begin
      cas_width = ras_low_clocks - CW'(1);
    end
  end

  // ==========================================================================
  // time-out monitor
  bdc_timeout #(
    .LIMIT(LIMIT)
  ) u_timeout (
    .clock                   (clock),
    .rst                     (rst),
    .cycle_active            (cycle_active),
    .cycle_done              (dram_done),
    .request_clear           (request_clear),
    .force_ready             (force_ready),
    .timeout_indicator       (timeout_indicator),
    .nmi_factor              (nmi_factor),
    .bus_error_interrupt_line(bus_error_interrupt_line)
  );

  // ==========================================================================
  // main sequencer
  // one process owns state and strobes so the dram pins never glitch apart
  always_ff @(posedge clock) begin
    if (rst) begin
      state                <= bdc_pkg::BDC_IDLE;
      count                <= '0;
      ras_count            <= '0;
      row_strobe_n         <= 1'b1;
      byte_column_strobe_n <= '1;
      write_enable_n       <= 1'b1;
      wait_n               <= 1'b1;
      dram_done            <= 1'b0;
    end else begin
      dram_done <= 1'b0;
      if (ras_count != '0) begin
        ras_count <= ras_count - CW'(1);
      end
      unique case (state)
        bdc_pkg::BDC_IDLE: begin
          wait_n <= 1'b1;
          if (!data_strobe_n && dram_select && wait_n) begin
            wait_n         <= 1'b0;
            write_enable_n <= !write;
            if (page_mode && same_row) begin
              // page hit skips row open, saving at least one wait
              state <= bdc_pkg::BDC_CAS;
              count <= cas_width;
              byte_column_strobe_n <= ~byte_enable;
            end else if (!row_strobe_n) begin
              // row left open by page mode and not hit: close and precharge first
              row_strobe_n <= 1'b1;
              state        <= bdc_pkg::BDC_PRE;
              count        <= at_least_one(precharge_clocks);
            end else if (count != '0) begin
              state <= bdc_pkg::BDC_PRE;
            end else begin
              row_strobe_n <= 1'b0;
              state        <= bdc_pkg::BDC_RAS;
              ras_count    <= at_least_one(ras_low_clocks);
            end
          end else if (count != '0) begin
            count <= count - CW'(1); // trailing precharge of last access
          end
        end
        bdc_pkg::BDC_PRE: begin
          if (count <= CW'(1)) begin
            count        <= '0;
            row_strobe_n <= 1'b0;
            state        <= bdc_pkg::BDC_RAS;
            ras_count    <= at_least_one(ras_low_clocks);
          end else begin
            count <= count - CW'(1);
          end
        end
        bdc_pkg::BDC_RAS: begin
          byte_column_strobe_n <= ~byte_enable;
          count                <= cas_width;
          state                <= bdc_pkg::BDC_CAS;
        end
        bdc_pkg::BDC_CAS: begin
          if (count <= CW'(1)) begin
            byte_column_strobe_n <= '1;
            wait_n               <= 1'b1;
            dram_done            <= 1'b1;
            state                <= bdc_pkg::BDC_DONE;
          end else begin
            count <= count - CW'(1);
          end
        end
        bdc_pkg::BDC_DONE: begin
          if (page_mode) begin
            state <= bdc_pkg::BDC_WAITE;
          end else if (ras_count == '0) begin
            // normal mode closes the row every access, never before the row-low minimum
            row_strobe_n <= 1'b1;
            count        <= at_least_one(precharge_clocks);
            state        <= bdc_pkg::BDC_WAITE;
          end
        end
        bdc_pkg::BDC_WAITE: begin
          write_enable_n <= 1'b1;
          if (count != '0) begin
            count <= count - CW'(1);
          end
          if (data_strobe_n) begin
            state <= bdc_pkg::BDC_IDLE; // wait for processor to end its cycle
          end
        end
        default: begin
          state <= bdc_pkg::BDC_IDLE;
        end
      endcase
      if (force_ready) begin
        // stalled cycle ended by the monitor; drop everything
        wait_n               <= 1'b1;
        row_strobe_n         <= 1'b1;
        byte_column_strobe_n <= '1;
        write_enable_n       <= 1'b1;
        state                <= bdc_pkg::BDC_WAITE;
        count                <= at_least_one(precharge_clocks);
      end
    end
  end

  // ==========================================================================
  // open row tracking
  always_ff @(posedge clock) begin
    if (rst) begin
      open_row     <= '0;
      row_open     <= 1'b0;
      first_of_run <= 1'b1;
      row_hit      <= 1'b0;
    end else begin
      if (state == bdc_pkg::BDC_IDLE && !data_strobe_n && dram_select && wait_n) begin
        row_hit      <= same_row;
        first_of_run <= !(page_mode && same_row);
        open_row     <= address[ADDR_W-1:ROW_LSB];
      end
      if (state == bdc_pkg::BDC_CAS) begin
        first_of_run <= 1'b0;
      end
      if (state == bdc_pkg::BDC_RAS) begin
        row_open <= page_mode;
      end
      if (force_ready || (state == bdc_pkg::BDC_DONE && !page_mode)) begin
        row_open <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// File: verif/bdc_dram_props.sv
// checker for the dram controller: strobes, precharge, time-out flags
// assumes binding onto bdc_dram_ctrl and a synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none
module bdc_dram_props #(
  parameter int LANES = 4,
  parameter int LIMIT = 1024
) (
  // clock, reset and bus side
  input wire logic                      clock,
  input wire logic                      rst,
  input wire logic                      data_strobe_n,
  input wire logic                      address_strobe,
  input wire logic                      write,
  input wire logic [LANES-1:0]          byte_enable,
  input wire logic                      request_clear,
  input wire logic [bdc_pkg::CNT_W-1:0] precharge_clocks,
  input wire logic [bdc_pkg::CNT_W-1:0] ras_low_clocks,
  // dram side and flags
  input wire logic                      wait_n,
  input wire logic                      row_strobe_n,
  input wire logic [LANES-1:0]          byte_column_strobe_n,
  input wire logic                      write_enable_n,
  input wire logic                      timeout_indicator,
  input wire logic                      nmi_factor,
  input wire logic                      bus_error_interrupt_line
);
  // ==========================================================================
  // run lengths, not reset so a run spanning a reset is still measured
  logic [15:0] dlo = 16'h0000;
  logic [15:0] rhc = 16'h0000;
  logic [15:0] rlc = 16'h0000;
  always_ff @(posedge clock) begin
    dlo <= data_strobe_n ? 16'h0000 : dlo + 16'h0001;
  end
  always_ff @(posedge clock) begin
    rhc <= row_strobe_n ? rhc + 16'h0001 : 16'h0000;
    rlc <= row_strobe_n ? 16'h0000 : rlc + 16'h0001;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // ==========================================================================
  // properties
  reset_idle_a: assert property (disable iff (1'b0) rst |=>
    row_strobe_n && (&byte_column_strobe_n) && write_enable_n && wait_n && !timeout_indicator)
    else $error("outputs not idle after reset");
  flag_hold_a: assert property (timeout_indicator && !request_clear |=> timeout_indicator)
    else $error("time-out flag dropped without clear");
  flag_clear_a: assert property (timeout_indicator && request_clear && data_strobe_n && !address_strobe |=> !timeout_indicator)
    else $error("time-out flag not cleared");
  flags_match_a: assert property ({nmi_factor, bus_error_interrupt_line} == {2{timeout_indicator}})
    else $error("interrupt factors differ from indicator");
  lane_select_a: assert property (!data_strobe_n |-> (~byte_column_strobe_n & ~byte_enable) == '0)
    else $error("unused lane strobed");
  cas_ras_a: assert property (!(&byte_column_strobe_n) |-> !row_strobe_n)
    else $error("column strobe without row strobe");
  precharge_gap_a: assert property ($fell(row_strobe_n) |-> rhc >= {12'h000, precharge_clocks})
    else $error("row precharge too short");
  ras_width_a: assert property ($rose(row_strobe_n) |-> rlc >= {12'h000, ras_low_clocks})
    else $error("row strobe low too short");
  stall_timeout_a: assert property (dlo == LIMIT |-> ##[1:4] timeout_indicator)
    else $error("stalled cycle not timed out");
  we_match_a: assert property (!(&byte_column_strobe_n) |-> write_enable_n == !write)
    else $error("write enable does not follow cycle direction");
endmodule
bind bdc_dram_ctrl bdc_dram_props #(.LANES(LANES), .LIMIT(LIMIT)) u_bdc_dram_props (
  .clock(clock), .rst(rst), .data_strobe_n(data_strobe_n), .address_strobe(address_strobe), .write(write),
  .byte_enable(byte_enable),
  .request_clear(request_clear), .precharge_clocks(precharge_clocks), .ras_low_clocks(ras_low_clocks),
  .wait_n(wait_n), .row_strobe_n(row_strobe_n), .byte_column_strobe_n(byte_column_strobe_n),
  .write_enable_n(write_enable_n), .timeout_indicator(timeout_indicator), .nmi_factor(nmi_factor),
  .bus_error_interrupt_line(bus_error_interrupt_line)
);
`default_nettype wire

// File: verif/bdc_cpu_model.sv
// processor bus model: runs one external cycle and records the dram strobes
// assumes the controller extends cycles by holding wait_n low
`timescale 1ns/10ps
`default_nettype none
module bdc_cpu_model (
  // controller answers
  input  wire logic       clock,
  input  wire logic       wait_n,
  input  wire logic       row_strobe_n,
  input  wire logic [3:0] byte_column_strobe_n,
  // cycle strobes and address
  output var logic        address_strobe,
  output var logic        data_strobe_n,
  output var logic        write,
  output var logic [21:0] address,
  output var logic [3:0]  byte_enable
);
  // ==========================================================================
  // idle bus at time zero
  initial begin
    address_strobe = 1'b0;
    data_strobe_n = 1'b1;
    write = 1'b0;
    address = 22'h000000;
    byte_enable = 4'h0;
  end
  // stall above zero holds the cycle that long whatever wait_n says
  task automatic bus_cycle(input logic wr, input logic [21:0] a, input logic [3:0] be, input int stall,
                           output int waits, output int casw, output logic [3:0] lanes, output logic rhi);
    int n = 0;
    logic seen = 1'b0;
    waits = 0;
    casw = 0;
    lanes = 4'h0;
    rhi = 1'b0;
    @(posedge clock);
    address_strobe <= 1'b1;
    data_strobe_n <= 1'b0;
    write <= wr;
    address <= a;
    byte_enable <= be;
    do begin
      @(posedge clock);
      address_strobe <= 1'b0;
      n++;
      waits += int'(!wait_n);
      casw += int'(!(&byte_column_strobe_n));
      lanes |= ~byte_column_strobe_n;
      rhi |= row_strobe_n;
      seen |= !wait_n;
    end while (n < 200 && (stall > 0 ? n < stall : !(seen && wait_n)));
    // released lines show the inverse so a stale value cannot pass
    data_strobe_n <= 1'b1;
    address <= ~a;
    byte_enable <= ~be;
    @(posedge clock);
  endtask
endmodule
`default_nettype wire

// File: verif/testbench.sv
// self-checking bench for the dram controller with time-out monitor
// assumes the cpu model drives the bus and the checker is bound
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int LIM = 32;
  typedef struct {logic pm; logic wr; logic [21:0] a; logic [3:0] be; logic ck; logic hit; logic [3:0] cw;} bdc_row_t;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic dram_select = 1'b1;
  logic page_mode = 1'b0;
  logic request_clear = 1'b0;
  logic [3:0] precharge_clocks = 4'h2;
  logic [3:0] ras_low_clocks = 4'h4;
  logic [3:0] read_cas_clocks = 4'h1;
  logic address_strobe, data_strobe_n, write, wait_n, row_strobe_n, write_enable_n, row_hit, rh;
  logic timeout_indicator, nmi_factor, bus_error_interrupt_line;
  logic [21:0] address;
  logic [3:0] byte_enable, byte_column_strobe_n, ln;
  int fails = 0;
  int checked = 0;
  int w [7];
  int cw, w1, w2;
  // row-low 4, read cas 1: first accesses stretch to 3
  bdc_row_t rows [7] = '{
    '{1'b0, 1'b0, 22'h000010, 4'hF, 1'b0, 1'b0, 4'h3},
    '{1'b0, 1'b1, 22'h000010, 4'h3, 1'b0, 1'b0, 4'h3},
    '{1'b1, 1'b0, 22'h000010, 4'hC, 1'b0, 1'b0, 4'h3},
    '{1'b1, 1'b0, 22'h000024, 4'h1, 1'b1, 1'b1, 4'h1},
    '{1'b1, 1'b1, 22'h000024, 4'h2, 1'b1, 1'b1, 4'h1},
    '{1'b1, 1'b0, 22'h000810, 4'hF, 1'b1, 1'b0, 4'h3},
    '{1'b1, 1'b0, 22'h000810, 4'h8, 1'b1, 1'b1, 4'h1}};
  always #5 clock = ~clock;
  bdc_dram_ctrl #(.LIMIT(LIM)) u_bdc_dram_ctrl (
    .clock(clock), .rst(rst), .address_strobe(address_strobe), .data_strobe_n(data_strobe_n),
    .dram_select(dram_select), .write(write), .address(address), .byte_enable(byte_enable), .wait_n(wait_n),
    .page_mode(page_mode), .precharge_clocks(precharge_clocks), .ras_low_clocks(ras_low_clocks),
    .read_cas_clocks(read_cas_clocks), .row_strobe_n(row_strobe_n), .byte_column_strobe_n(byte_column_strobe_n),
    .write_enable_n(write_enable_n), .row_hit(row_hit), .request_clear(request_clear),
    .timeout_indicator(timeout_indicator), .nmi_factor(nmi_factor), .bus_error_interrupt_line(bus_error_interrupt_line));
  bdc_cpu_model u_bdc_cpu_model (
    .clock(clock), .wait_n(wait_n), .row_strobe_n(row_strobe_n), .byte_column_strobe_n(byte_column_strobe_n),
    .address_strobe(address_strobe), .data_strobe_n(data_strobe_n), .write(write), .address(address),
    .byte_enable(byte_enable));
  // ==========================================================================
  // comparison and verdict
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    if (fails == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ==========================================================================
  // table, then precharge, reset and time-out cases
  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    foreach (rows[i]) begin
      page_mode <= rows[i].pm;
      u_bdc_cpu_model.bus_cycle(rows[i].wr, rows[i].a, rows[i].be, 0, w[i], cw, ln, rh);
      check(16'(ln), 16'(rows[i].be));
      check(16'(cw), 16'(rows[i].cw));
      if (rows[i].ck) check(16'({rh, row_hit}), 16'({!rows[i].hit, rows[i].hit}));
    end
    check(16'(w[3] < w[0]), 16'h0001);
    page_mode <= 1'b0;
    precharge_clocks <= 4'h6;
    // first access closes the page row left open; let its precharge run out
    u_bdc_cpu_model.bus_cycle(1'b0, 22'h000810, 4'hF, 0, w1, cw, ln, rh);
    repeat (10) @(posedge clock);
    u_bdc_cpu_model.bus_cycle(1'b0, 22'h000810, 4'hF, 0, w1, cw, ln, rh);
    u_bdc_cpu_model.bus_cycle(1'b0, 22'h000810, 4'hF, 0, w2, cw, ln, rh);
    check(16'(w2 > w1), 16'h0001);
    page_mode <= 1'b1;
    u_bdc_cpu_model.bus_cycle(1'b0, 22'h000010, 4'hF, 0, w1, cw, ln, rh);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    #1 check(16'({row_strobe_n, byte_column_strobe_n, write_enable_n, wait_n}), 16'h007F);
    repeat (6) @(posedge clock);
    u_bdc_cpu_model.bus_cycle(1'b0, 22'h000010, 4'hF, 0, w1, cw, ln, rh);
    check(16'(row_hit), 16'h0000);
    dram_select <= 1'b0;
    repeat (2) u_bdc_cpu_model.bus_cycle(1'b0, 22'h000000, 4'hF, LIM - 4, w1, cw, ln, rh);
    check(16'(timeout_indicator), 16'h0000);
    u_bdc_cpu_model.bus_cycle(1'b0, 22'h000000, 4'hF, LIM + 8, w1, cw, ln, rh);
    check(16'({timeout_indicator, nmi_factor, bus_error_interrupt_line}), 16'h0007);
    repeat (3) @(posedge clock);
    check(16'({timeout_indicator, nmi_factor, bus_error_interrupt_line}), 16'h0007);
    request_clear <= 1'b1;
    @(posedge clock);
    request_clear <= 1'b0;
    @(posedge clock);
    #1 check(16'({timeout_indicator, nmi_factor, bus_error_interrupt_line}), 16'h0000);
    final_report;
  end
  // whole run needs well under a thousand clocks
  initial begin
    repeat (3000) @(posedge clock);
    fails++;
    final_report;
  end
endmodule
`default_nettype wire
